// file: hdl/eeprom_dev.sv
// EEPROM device end: serial decoder, write and write-all sequencer.
// Assumes link pins are asynchronous to ref_clk_i.
`timescale 1ns/1ps
module eeprom_dev
   import eeprom_seq_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   // Link
   eeprom_link_if.dev             link,
   // Status
   output logic                   busy_o,
   output logic                   prog_en_o
);
   typedef enum logic [1:0] {
      D_IDLE = 2'b00,
      D_SHIFT = 2'b01,
      D_WAIT = 2'b10
   } dstate_t;

   logic [1:0]         cs_s_r, sck_s_r, din_s_r;
   logic               sck_d_r, cs_d_r;
   dstate_t            st_r;
   logic [CNT_W-1:0]   cnt_r;
   logic [FRAME_BITS-2:0] sh_r;
   logic [WORD_W-1:0]  mem_r [DEPTH];
   logic               en_r, busy_r, all_r, erased_r;
   logic [ADDR_W-1:0]  addr_r;
   logic [WORD_W-1:0]  data_r;
   logic [15:0]        tmr_r;
   logic [7:0]         csl_r;
   logic               dout_r, oe_n_r;

   wire cs_w   = cs_s_r[1];
   wire rise_w = sck_s_r[1] & ~sck_d_r;
   wire cs_fall_w = cs_d_r & ~cs_w;
   wire cs_rise_w = ~cs_d_r & cs_w;
   // Opcode is the oldest pair shifted in after the start bit
   wire [1:0] op_w  = sh_r[HDR_BITS-1 -: 2];
   wire [1:0] ext_w = sh_r[HDR_BITS-3 -: 2];
   wire is_wr_w  = (cnt_r == ALL_BITS) && (sh_r[ALL_BITS-1 -: 2] == OP_WRITE);
   wire is_all_w = (cnt_r == ALL_BITS) && (sh_r[ALL_BITS-1 -: 2] == OP_EXT)
                   && (sh_r[ALL_BITS-3 -: 2] == EXT_ALL);
   wire hdr_w    = (cnt_r == HDR_BITS) && (op_w == OP_EXT);

   always_ff @(posedge ref_clk_i) begin
      cs_s_r  <= {cs_s_r[0], link.cs};
      sck_s_r <= {sck_s_r[0], link.sck};
      din_s_r <= {din_s_r[0], link.serial_in_line};
      sck_d_r <= sck_s_r[1];
      cs_d_r  <= cs_w;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_r <= D_IDLE;
         cnt_r <= '0;
         sh_r <= '0;
         en_r <= 1'b0;
         busy_r <= 1'b0;
         all_r <= 1'b0;
         erased_r <= 1'b0;
         addr_r <= '0;
         data_r <= '0;
         tmr_r <= '0;
      end else begin
         case (st_r)
            D_IDLE: begin
               if (cs_w && rise_w && din_s_r[1]) begin
                  st_r <= D_SHIFT;
                  cnt_r <= '0;
               end
            end
            D_SHIFT: begin
               if (!cs_w) begin
                  st_r <= D_IDLE;
                  if (en_r && (is_wr_w || is_all_w)) begin
                     busy_r <= 1'b1;
                     all_r <= is_all_w;
                     erased_r <= 1'b0;
                     addr_r <= sh_r[WORD_W +: ADDR_W];
                     data_r <= sh_r[WORD_W-1:0];
                     tmr_r <= PROG_CYC;
                     st_r <= D_WAIT;
                  end
               end else if (rise_w && cnt_r != ALL_BITS) begin
                  sh_r <= {sh_r[FRAME_BITS-3:0], din_s_r[1]};
                  cnt_r <= cnt_r + 1'b1;
               end
               if (hdr_w && ext_w == EXT_ENABLE) en_r <= 1'b1;
               if (hdr_w && ext_w == EXT_DISABLE) en_r <= 1'b0;
            end
            D_WAIT: begin
               // Runs on ref_clk only; serial clock ignored
               if (tmr_r != '0) begin
                  tmr_r <= tmr_r - 1'b1;
               end else if (all_r && !erased_r) begin
                  erased_r <= 1'b1;
                  tmr_r <= PROG_CYC;
               end else begin
                  busy_r <= 1'b0;
                  st_r <= D_IDLE;
               end
            end
            default: st_r <= D_IDLE;
         endcase
      end
   end

   // Array update: erase phase (write-all only) then program phase
   always_ff @(posedge ref_clk_i) begin
      if (st_r == D_WAIT && tmr_r == '0) begin
         for (int i = 0; i < DEPTH; i++) begin
            if (all_r && !erased_r) mem_r[i] <= ERASED_WORD;
            else if (all_r || addr_r == ADDR_W'(i)) mem_r[i] <= data_r;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         csl_r <= '0;
         dout_r <= 1'b1;
         oe_n_r <= 1'b1;
      end else begin
         if (cs_w) csl_r <= '0;
         else if (csl_r != CSL_CYC) csl_r <= csl_r + 1'b1;
         if (cs_fall_w) oe_n_r <= 1'b1;
         else if (cs_rise_w && csl_r == CSL_CYC && st_r != D_SHIFT) oe_n_r <= 1'b0;
         if (busy_r) dout_r <= 1'b0;
         else dout_r <= 1'b1;
      end
   end

   assign link.dout = dout_r;
   assign link.dout_oe_n = oe_n_r;
   assign busy_o = busy_r;
   assign prog_en_o = en_r;
endmodule

// file: hdl/eeprom_host.sv
// Host controller end: frames enable, write and write-all, polls status.
// Assumes a request is held only while ready_o is high.
`timescale 1ns/1ps
module eeprom_host
   import eeprom_seq_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   // Request
   input  wire logic              req_i,
   input  wire logic [1:0]        kind_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [WORD_W-1:0] data_i,
   output logic                   ready_o,
   output logic                   done_o,
   // Link
   eeprom_link_if.host            link
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SEND = 2'b01,
      H_GAP = 2'b10,
      H_POLL = 2'b11
   } hstate_t;

   hstate_t              st_r;
   logic [FRAME_BITS-1:0] sh_r;
   logic [CNT_W-1:0]     left_r;
   logic [7:0]           div_r;
   logic                 sck_r, cs_r, din_r, wait_r, done_r, ready_r;
   logic [1:0]           rdy_s_r;

   wire tick_w = (div_r == SCK_HALF);
   // kind 0: enable, 1: write, 2: write-all, 3: disable
   wire [FRAME_BITS-1:0] frame_w =
      (kind_i == 2'h1) ? {1'b1, OP_WRITE, 1'b0, addr_i, data_i} :
      (kind_i == 2'h2) ? {1'b1, OP_EXT, EXT_ALL, 6'h00, data_i} :
      (kind_i == 2'h0) ? {1'b1, OP_EXT, EXT_ENABLE, 6'h00, 16'h0000} :
                         {1'b1, OP_EXT, EXT_DISABLE, 6'h00, 16'h0000};
   wire [CNT_W-1:0] len_w = kind_i[0] ^ kind_i[1] ? CNT_W'(FRAME_BITS) : CNT_W'(HDR_BITS + 1'b1);

   always_ff @(posedge ref_clk_i) rdy_s_r <= {rdy_s_r[0], link.dout_line};

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_r <= H_IDLE;
         sh_r <= '0;
         left_r <= '0;
         div_r <= '0;
         sck_r <= 1'b0;
         cs_r <= 1'b0;
         din_r <= 1'b0;
         wait_r <= 1'b0;
         done_r <= 1'b0;
         ready_r <= 1'b1;
      end else begin
         done_r <= 1'b0;
         div_r <= tick_w ? '0 : div_r + 1'b1;
         case (st_r)
            H_IDLE: begin
               if (req_i) begin
                  // First bit waits on the data line before the first rise
                  din_r <= frame_w[FRAME_BITS-1];
                  sh_r <= {frame_w[FRAME_BITS-2:0], 1'b0};
                  left_r <= len_w;
                  wait_r <= kind_i[0] ^ kind_i[1];
                  ready_r <= 1'b0;
                  cs_r <= 1'b1;
                  sck_r <= 1'b0;
                  div_r <= '0;
                  st_r <= H_SEND;
               end
            end
            H_SEND: if (tick_w) begin
               if (!sck_r) begin
                  if (left_r == '0) begin
                     cs_r <= 1'b0;
                     st_r <= H_GAP;
                  end else begin
                     sck_r <= 1'b1;
                  end
               end else begin
                  // Next bit changes while the clock is low
                  sck_r <= 1'b0;
                  din_r <= sh_r[FRAME_BITS-1];
                  sh_r <= {sh_r[FRAME_BITS-2:0], 1'b0};
                  left_r <= left_r - 1'b1;
               end
            end
            H_GAP: if (tick_w) begin
               // Low for several half periods, well over the minimum
               left_r <= left_r + 1'b1;
               if (left_r == CNT_W'(CSL_CYC)) begin
                  if (wait_r) begin
                     cs_r <= 1'b1;
                     st_r <= H_POLL;
                  end else begin
                     done_r <= 1'b1;
                     ready_r <= 1'b1;
                     st_r <= H_IDLE;
                  end
               end
            end
            H_POLL: begin
               // No serial clocks while waiting
               if (tick_w) begin
                  // First tick lets driven status pass both synchronisers
                  wait_r <= 1'b0;
                  if (!wait_r && rdy_s_r[1]) begin
                     cs_r <= 1'b0;
                     done_r <= 1'b1;
                     ready_r <= 1'b1;
                     st_r <= H_IDLE;
                  end
               end
            end
            default: begin
               st_r <= H_IDLE;
               ready_r <= 1'b1;
            end
         endcase
      end
   end

   assign link.cs = cs_r;
   assign link.sck = sck_r;
   assign link.serial_in_line = din_r;
   assign ready_o = ready_r;
   assign done_o = done_r;
endmodule

// file: hdl/eeprom_link_if.sv
// Three-wire link between host controller and EEPROM device.
// Data out is resolved from the device enable (low = driving).
`timescale 1ns/1ps
interface eeprom_link_if;
   logic cs;
   logic sck;
   logic serial_in_line;
   logic dout;
   logic dout_oe_n;
   logic dout_line;
   assign dout_line = dout_oe_n ? 1'b1 : dout;
   modport dev  (input cs, input sck, input serial_in_line, output dout, output dout_oe_n);
   modport host (output cs, output sck, output serial_in_line, input dout_line);
endinterface

// file: hdl/eeprom_seq_pkg.sv
// Behaviour
// - Write carries one 8 or 16 bit word (16-bit word only here)
// - Chip select fall launches erase then program (single write here programs with no separate erase phase)
// - Select high after low time shows status
// - Busy reads low on data out
// - Done reads high on data out
// - Write-all loads every location with word
// - Write-all starts on chip select fall
// - Write-all needs no further serial clocks
// - Write-all erases whole array first
// - Write-all only while programming enabled
// - Start is first rising edge, select and data high
// - Bits sampled on rising serial clock
// - Data out floats when select falls
// - Programming disabled after reset
//
// Constants shared by both ends of the three-wire EEPROM link.
// Assumes a 100 MHz system clock on both ends.
package eeprom_seq_pkg;
   localparam int          WORD_W        = 16;
   localparam int          ADDR_W        = 7;
   localparam int          DEPTH         = 128;
   // One don't-care bit leads the address field
   localparam int          FRAME_BITS    = 1 + 2 + 1 + ADDR_W + WORD_W;
   localparam int          CNT_W         = 5;
   localparam logic [4:0]  HDR_BITS      = 5'h0A;
   localparam logic [4:0]  ALL_BITS      = 5'h1A;
   localparam logic [1:0]  OP_WRITE      = 2'h1;
   localparam logic [1:0]  OP_EXT        = 2'h0;
   localparam logic [1:0]  EXT_ALL       = 2'h1;
   localparam logic [1:0]  EXT_ENABLE    = 2'h3;
   localparam logic [1:0]  EXT_DISABLE   = 2'h0;
   localparam logic [1:0]  EXT_ERASE_ALL = 2'h2;
   localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
   localparam int          CLK_MHZ       = 100;
   localparam int          CSL_NS        = 250;
   localparam logic [7:0]  CSL_CYC       = 8'((CSL_NS * CLK_MHZ + 999) / 1000);
   localparam int          PROG_US       = 10;
   localparam logic [15:0] PROG_CYC      = 16'(PROG_US * CLK_MHZ);
   localparam logic [7:0]  SCK_HALF      = 8'h04;
endpackage

// file: testbench/eeprom_link_monitor.sv
// Concurrent checks on the link between host and device ends.
// Assumes link pins change only on ref_clk_i edges.
`timescale 1ns/1ps
module eeprom_link_monitor
   import eeprom_seq_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Link and device status
   input wire logic cs,
   input wire logic sck,
   input wire logic dout,
   input wire logic dout_oe_n,
   input wire logic busy_o,
   input wire logic prog_en_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   a_float_on_deselect: assert property ($fell(cs) |-> ##[1:6] dout_oe_n)
      else $error("data out still driven after deselect");
   a_busy_reads_low: assert property (busy_o && $past(busy_o, 2) && !dout_oe_n |-> !dout)
      else $error("status high while programming");
   a_ready_reads_high: assert property (!busy_o && !$past(busy_o, 2) && !dout_oe_n |-> dout)
      else $error("status low while idle");
   a_start_when_low: assert property ($rose(busy_o) |-> !cs)
      else $error("programming started with select high");
   a_start_needs_en: assert property ($rose(busy_o) |-> prog_en_o)
      else $error("programming started while disabled");
   a_no_clock_busy: assert property (busy_o |-> !$rose(sck))
      else $error("serial clock pulsed during programming");
   a_status_on_select: assert property ($rose(cs) && busy_o |-> ##[1:6] !dout_oe_n)
      else $error("status not driven on reselect");
   a_enable_kept: assert property (busy_o && $past(busy_o) |-> $stable(prog_en_o))
      else $error("enable changed during programming");
   // Erase plus program, with a few cycles of slack
   localparam int BUSY_MAX = 2 * PROG_CYC + 8;
   logic [11:0]   busy_len_r;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !busy_o) busy_len_r <= '0;
      else if (busy_len_r != 12'hFFF) busy_len_r <= busy_len_r + 12'h001;
   end
   a_busy_bounded: assert property (busy_len_r <= 12'(BUSY_MAX))
      else $error("programming did not finish");
   a_disabled_reset: assert property ($fell(rst_i) |-> !prog_en_o)
      else $error("enabled right after reset");
endmodule

// file: testbench/serial_eeprom_write_sequencer_tb.sv
// Bench joining host and device ends over the three-wire link.
// Assumes frames with 27 or 11 bits and 16-bit words.
`timescale 1ns/1ps
module serial_eeprom_write_sequencer_tb
   import eeprom_seq_pkg::*;
;
   logic              ref_clk_i = 1'b0;
   logic              rst_i     = 1'b1;
   logic              req_i     = 1'b0;
   logic [1:0]        kind_i    = 2'h0;
   logic [ADDR_W-1:0] addr_i    = '0;
   logic [WORD_W-1:0] data_i    = '0;
   logic              ready_o;
   logic              done_o;
   logic              busy_o;
   logic              prog_en_o;
   logic [31:0]       shreg     = 32'h0;
   logic [1:0]        plan [8]  = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h1};
   int                err_count = 0;
   int                compares  = 0;
   int                sck_cnt   = 0;
   int                busy_cnt  = 0;
   int                exp_en    = 0;
   logic [WORD_W-1:0] ref_mem   [DEPTH];
   bit                ref_known [DEPTH];

   eeprom_link_if link ();
   eeprom_host eeprom_host_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i),
      .kind_i(kind_i), .addr_i(addr_i), .data_i(data_i), .ready_o(ready_o),
      .done_o(done_o), .link(link));
   eeprom_dev eeprom_dev_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link),
      .busy_o(busy_o), .prog_en_o(prog_en_o));
   eeprom_link_monitor eeprom_link_monitor_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .cs(link.cs), .sck(link.sck), .dout(link.dout), .dout_oe_n(link.dout_oe_n),
      .busy_o(busy_o), .prog_en_o(prog_en_o));

   always #5 ref_clk_i = ~ref_clk_i;

   // Wire capture of each frame, MSB first
   always @(posedge link.sck) begin
      sck_cnt++;
      shreg = {shreg[30:0], link.serial_in_line};
   end

   always @(posedge ref_clk_i) begin
      if (busy_o === 1'b1) busy_cnt++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("Counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic run_op(input logic [1:0] k);
      int         n;
      int         nb;
      int         need;
      logic [4:0] hdr;
      logic       prog;
      @(posedge ref_clk_i);
      #1;
      kind_i = k;
      addr_i = ADDR_W'($urandom);
      data_i = WORD_W'($urandom);
      sck_cnt = 0;
      busy_cnt = 0;
      req_i = 1'b1;
      while (ready_o !== 1'b1) begin
         @(posedge ref_clk_i);
         #1;
      end
      @(posedge ref_clk_i);
      #1;
      req_i = 1'b0;
      n = 0;
      while (n < 5000) begin
         @(posedge ref_clk_i);
         #1;
         if (done_o === 1'b1) break;
         n++;
      end
      if (n == 5000) check(32'h0, 32'h1);
      // Reference model of the device
      nb = (k == 2'h1 || k == 2'h2) ? 27 : 11;
      need = (k == 2'h2) ? 2 * PROG_CYC : PROG_CYC;
      prog = (nb == 27) && (exp_en != 0);
      case (k)
         2'h0: hdr = {1'b1, OP_EXT, EXT_ENABLE};
         2'h1: hdr = {1'b1, OP_WRITE, 1'b0, addr_i[6]};
         2'h2: hdr = {1'b1, OP_EXT, EXT_ALL};
         default: hdr = {1'b1, OP_EXT, EXT_DISABLE};
      endcase
      if (k == 2'h0) exp_en = 1;
      if (k == 2'h3) exp_en = 0;
      check(sck_cnt, nb);
      check(shreg[nb-1 -: 5], hdr);
      if (k == 2'h1) check(shreg[26:0], {hdr, addr_i[5:0], data_i});
      if (k == 2'h2) check(shreg[15:0], data_i);
      if (prog && k == 2'h1) begin
         ref_mem[addr_i] = data_i;
         ref_known[addr_i] = 1'b1;
      end
      if (prog && k == 2'h2) begin
         foreach (ref_mem[j]) begin
            ref_mem[j] = data_i;
            ref_known[j] = 1'b1;
         end
      end
      if (ref_known[addr_i]) check(eeprom_dev_inst.mem_r[addr_i], ref_mem[addr_i]);
      if (ref_known[~addr_i]) check(eeprom_dev_inst.mem_r[~addr_i], ref_mem[~addr_i]);
      check(prog ? busy_cnt >= need : busy_cnt == 0, 1'b1);
      check(prog_en_o, exp_en);
      $display("Test kind %0d finished", k);
   endtask

   initial begin
      #400000;
      err_count++;
      close_out();
   end

   initial begin
      void'($urandom(42176));
      repeat (8) @(posedge ref_clk_i);
      #1;
      rst_i = 1'b0;
      check(prog_en_o, 1'b0);
      foreach (plan[i]) run_op(plan[i]);
      close_out();
   end
endmodule
